// ===== hdl/drm_pkg.sv
package drm_pkg;

    localparam int CLK_PERIOD_PS = 4000;

    function automatic int ceil_div(input int num, input int den);
        return (num + den - 1) / den;
    endfunction : ceil_div

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : max2

    // Counters load one less, so a check of zero lands on the exact edge
    function automatic logic [7:0] load_cnt(input logic [7:0] cyc);
        return (cyc == 8'h00) ? 8'h00 : cyc - 8'h01;
    endfunction : load_cnt

    function automatic logic [7:0] dec_cnt(input logic [7:0] cnt);
        return (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
    endfunction : dec_cnt

    // Times in picoseconds, plain defaults for one speed grade
    localparam int T_RP_PS = 15000;
    localparam int T_RPA_PS = 17500;
    localparam int T_RFC_PS = 127500;
    localparam int T_XSNR_PS = 137500;
    localparam int T_WTR_PS = 7500;
    localparam int T_WR_PS = 15000;
    localparam int T_REFI_PS = 7812500;
    localparam int T_REFI_HOT_PS = 3900000;

    localparam logic [7:0] RP_CYC = 8'(ceil_div(T_RP_PS, CLK_PERIOD_PS));
    localparam logic [7:0] RPA_CYC = 8'(ceil_div(T_RPA_PS, CLK_PERIOD_PS));
    localparam logic [7:0] RFC_CYC = 8'(ceil_div(T_RFC_PS, CLK_PERIOD_PS));
    localparam logic [7:0] XSNR_CYC = 8'(ceil_div(T_XSNR_PS, CLK_PERIOD_PS));
    localparam int WTR_CYC = max2(2, ceil_div(T_WTR_PS, CLK_PERIOD_PS));
    localparam int WR_CYC = ceil_div(T_WR_PS, CLK_PERIOD_PS);
    localparam logic [7:0] XSRD_CYC = 8'hC8;
    localparam logic [7:0] XP_CYC = 8'h02;
    localparam logic [7:0] XARD_CYC = 8'h02;
    localparam logic [7:0] XARDS_CYC = 8'h07;
    localparam logic [7:0] MRD_CYC = 8'h02;
    localparam logic [1:0] CKE_MIN_CYC = 2'h3;
    // Burst plus postamble, command to completion
    localparam int BURST_CYC = 6;
    localparam logic [7:0] READ_BUSY_CYC = 8'(BURST_CYC);
    localparam logic [7:0] WRITE_BUSY_CYC =
        8'(BURST_CYC + max2(WR_CYC, WTR_CYC));
    // Longest intervals round down
    localparam logic [11:0] REFI_CYC = 12'(T_REFI_PS / CLK_PERIOD_PS);
    localparam logic [11:0] REFI_HOT_CYC = 12'(T_REFI_HOT_PS / CLK_PERIOD_PS);

    localparam int NUM_BANKS = 8;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_VIOL = 8'h08;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int CTRL_SLOW_EXIT_BIT = 0;
    localparam int CTRL_HOT_BIT = 1;

    // Sticky protocol error bits
    localparam int VIOL_W = 11;
    localparam int V_RDWR_IDLE = 0;
    localparam int V_BANK_BUSY = 1;
    localparam int V_SR_OPEN = 2;
    localparam int V_EXIT_CMD = 3;
    localparam int V_CKE_HOLD = 4;
    localparam int V_CKE_ACCESS = 5;
    localparam int V_REF_LATE = 6;
    localparam int V_EARLY_READ = 7;
    localparam int V_TERM = 8;
    localparam int V_REF_OPEN = 9;
    localparam int V_CKE_EXIT = 10;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic all_bank_select_addr_bit;
        logic [2:0] ba;
    } drm_cmd_type;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_PRE, CMD_REF, CMD_MRS, CMD_READ, CMD_WRITE
    } drm_op_type;

    typedef enum logic [1:0] {
        PS_NORMAL, PS_PD_PRE, PS_PD_ACT, PS_SELF_REF
    } drm_pstate_type;

    function automatic drm_op_type decode_cmd(input drm_cmd_type c);
        drm_op_type op;
        op = CMD_NOP;
        if (!c.cs_n)
        begin
            case ({c.ras_n, c.cas_n, c.we_n})
                3'b011: op = CMD_ACT;
                3'b010: op = CMD_PRE;
                3'b001: op = CMD_REF;
                3'b000: op = CMD_MRS;
                3'b101: op = CMD_READ;
                3'b100: op = CMD_WRITE;
                default: op = CMD_NOP;
            endcase
        end
        return op;
    endfunction : decode_cmd

endpackage : drm_pkg

// ===== hdl/drm_bank.sv
`timescale 1ns/100ps
module drm_bank
    import drm_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic act_i,
    input wire logic pre_i,
    input wire logic ref_i,
    input wire logic [7:0] load_i,
    output logic open_o,
    output logic busy_o
);

    logic open_q, open_d;
    logic busy_q, busy_d;
    logic [7:0] timer_q, timer_d;

    always_comb
    begin
        open_d = open_q;
        timer_d = dec_cnt(timer_q);
        if (act_i)
        begin
            open_d = 1'b1;
        end
        else if (pre_i || ref_i)
        begin
            open_d = 1'b0;
            timer_d = load_cnt(load_i);
        end
        busy_d = (timer_d != 8'h00);
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            open_q <= 1'b0;
            busy_q <= 1'b0;
            timer_q <= 8'h00;
        end
        else
        begin
            open_q <= open_d;
            busy_q <= busy_d;
            timer_q <= timer_d;
        end
    end

    assign open_o = open_q;
    assign busy_o = busy_q;

endmodule : drm_bank

// ===== hdl/drm_ctl.sv
// Behaviour
// - Precharge uses all-bank bit for all banks, else bank address picks one.
// - Precharged bank is idle; read or write to idle bank is flagged.
// - Refresh with clock-gate low enters self refresh; banks must be idle.
// - Self refresh exit delays count from first registered high clock-gate.
// - Write completes after postamble and the larger of recovery and write-to-read (two at least).
// - Power-down entered by clock-gate low with NOP; not mid access or MRS.
// - Idle banks give precharge power-down with frozen DLL, else active.
// - Power-down exit on clock-gate high with NOP, at same clock frequency.
`timescale 1ns/100ps
module drm_ctl
    import drm_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire drm_cmd_type cmd_i,
    input wire logic cke_i,
    input wire logic termination_enable_input_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [7:0] bank_open_o,
    output logic pd_precharge_o,
    output logic pd_active_o,
    output logic self_refresh_o,
    output logic dll_frozen_o,
    output logic buffers_off_o,
    output logic violation_o
);

    drm_pstate_type state_q, state_d;
    drm_op_type op;
    logic cke_prev_q, cke_prev_d;
    logic [1:0] run_q, run_d;
    logic [7:0] nonrd_q, nonrd_d;
    logic [7:0] rd_q, rd_d;
    logic [7:0] acc_q, acc_d;
    logic sr_win_q, sr_win_d;
    logic [11:0] debt_q, debt_d;
    logic [11:0] refi_lim;
    logic [VIOL_W-1:0] viol_q, viol_d, viol_set, viol_clr;
    logic [NUM_BANKS-1:0] act_v, pre_v, ref_v, open_v, busy_v;
    logic [7:0] pre_load;
    logic pd_pre_q, pd_pre_d, pd_act_q, pd_act_d, sr_q, sr_d;
    logic boff_q, boff_d, vio_q, vio_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic addr_phase;
    logic [7:0] acc_addr;

    // Bank timers
    for (genvar b = 0; b < NUM_BANKS; b++)
    begin : g_bank
        drm_bank u_bank (
            .sys_clk_i(sys_clk_i),
            .nrst_i(nrst_i),
            .act_i(act_v[b]),
            .pre_i(pre_v[b]),
            .ref_i(ref_v[b]),
            .load_i(ref_v[b] ? RFC_CYC : pre_load),
            .open_o(open_v[b]),
            .busy_o(busy_v[b])
        );
    end

    assign op = decode_cmd(cmd_i);
    assign refi_lim = ctrl_q[CTRL_HOT_BIT] ? REFI_HOT_CYC : REFI_CYC;

    always_comb
    begin
        state_d = state_q;
        cke_prev_d = cke_i;
        nonrd_d = dec_cnt(nonrd_q);
        rd_d = dec_cnt(rd_q);
        acc_d = dec_cnt(acc_q);
        sr_win_d = sr_win_q && (rd_d != 8'h00);
        debt_d = (debt_q == 12'hFFF) ? debt_q : debt_q + 12'h001;
        viol_set = '0;
        act_v = '0;
        pre_v = '0;
        ref_v = '0;
        pre_load = RP_CYC;
        if (cke_i != cke_prev_q)
        begin
            run_d = 2'h1;
            if (run_q < CKE_MIN_CYC)
            begin
                viol_set[V_CKE_HOLD] = 1'b1;
            end
        end
        else
        begin
            run_d = (run_q == CKE_MIN_CYC) ? run_q : run_q + 2'h1;
        end
        if (debt_q > refi_lim)
        begin
            viol_set[V_REF_LATE] = 1'b1;
        end
        if (termination_enable_input_i &&
            (state_q == PS_SELF_REF || sr_win_q))
        begin
            viol_set[V_TERM] = 1'b1;
        end
        case (state_q)
            PS_NORMAL:
            begin
                if (cke_prev_q && !cke_i)
                begin
                    if (sr_win_q && (nonrd_q != 8'h00 || op != CMD_REF))
                    begin
                        viol_set[V_CKE_EXIT] = 1'b1;
                    end
                    if (acc_q != 8'h00)
                    begin
                        viol_set[V_CKE_ACCESS] = 1'b1;
                    end
                    if (op == CMD_REF)
                    begin
                        state_d = PS_SELF_REF;
                        if (|open_v || |busy_v)
                        begin
                            viol_set[V_SR_OPEN] = 1'b1;
                        end
                        if (termination_enable_input_i)
                        begin
                            viol_set[V_TERM] = 1'b1;
                        end
                    end
                    else if (op == CMD_NOP)
                    begin
                        state_d = (|open_v) ? PS_PD_ACT : PS_PD_PRE;
                    end
                    else
                    begin
                        viol_set[V_CKE_ACCESS] = 1'b1;
                    end
                end
                else if (cke_prev_q)
                begin
                    if (op != CMD_NOP && op != CMD_READ && nonrd_q != 8'h00)
                    begin
                        viol_set[V_EXIT_CMD] = 1'b1;
                    end
                    if (op == CMD_READ && (rd_q != 8'h00 || nonrd_q != 8'h00))
                    begin
                        viol_set[V_EARLY_READ] = 1'b1;
                    end
                    case (op)
                        CMD_ACT:
                        begin
                            act_v[cmd_i.ba] = 1'b1;
                            viol_set[V_BANK_BUSY] = busy_v[cmd_i.ba];
                        end
                        CMD_PRE:
                        begin
                            if (cmd_i.all_bank_select_addr_bit)
                            begin
                                pre_v = '1;
                                pre_load = RPA_CYC;
                            end
                            else
                            begin
                                pre_v[cmd_i.ba] = 1'b1;
                            end
                        end
                        CMD_REF:
                        begin
                            viol_set[V_REF_OPEN] = |open_v;
                            viol_set[V_BANK_BUSY] = |busy_v;
                            ref_v = '1;
                            debt_d = (debt_q > refi_lim) ?
                                debt_q - refi_lim : 12'h000;
                        end
                        CMD_READ, CMD_WRITE:
                        begin
                            viol_set[V_RDWR_IDLE] = !open_v[cmd_i.ba];
                            acc_d = load_cnt(op == CMD_READ ?
                                READ_BUSY_CYC : WRITE_BUSY_CYC);
                        end
                        CMD_MRS:
                        begin
                            acc_d = load_cnt(MRD_CYC);
                        end
                        default:
                        begin
                            acc_d = dec_cnt(acc_q);
                        end
                    endcase
                end
            end
            PS_PD_PRE, PS_PD_ACT:
            begin
                if (cke_i)
                begin
                    state_d = PS_NORMAL;
                    viol_set[V_EXIT_CMD] = (op != CMD_NOP);
                    nonrd_d = load_cnt(XP_CYC);
                    if (state_q == PS_PD_ACT)
                    begin
                        rd_d = load_cnt(ctrl_q[CTRL_SLOW_EXIT_BIT] ?
                            XARDS_CYC : XARD_CYC);
                    end
                    else
                    begin
                        rd_d = load_cnt(XP_CYC);
                    end
                end
            end
            PS_SELF_REF:
            begin
                debt_d = 12'h000;
                if (cke_i)
                begin
                    state_d = PS_NORMAL;
                    viol_set[V_EXIT_CMD] = (op != CMD_NOP);
                    nonrd_d = load_cnt(XSNR_CYC);
                    rd_d = load_cnt(XSRD_CYC);
                    sr_win_d = 1'b1;
                end
            end
            default:
            begin
                state_d = PS_NORMAL;
            end
        endcase
        // Set wins over software clear
        viol_d = (viol_q & ~viol_clr) | viol_set;
        pd_pre_d = (state_d == PS_PD_PRE);
        pd_act_d = (state_d == PS_PD_ACT);
        sr_d = (state_d == PS_SELF_REF);
        // Own flops so the pins carry no decode glitches
        boff_d = (state_d != PS_NORMAL);
        vio_d = |viol_d;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= PS_NORMAL;
            cke_prev_q <= 1'b1;
            run_q <= CKE_MIN_CYC;
            nonrd_q <= 8'h00;
            rd_q <= 8'h00;
            acc_q <= 8'h00;
            sr_win_q <= 1'b0;
            debt_q <= 12'h000;
            viol_q <= '0;
            pd_pre_q <= 1'b0;
            pd_act_q <= 1'b0;
            sr_q <= 1'b0;
            boff_q <= 1'b0;
            vio_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cke_prev_q <= cke_prev_d;
            run_q <= run_d;
            nonrd_q <= nonrd_d;
            rd_q <= rd_d;
            acc_q <= acc_d;
            sr_win_q <= sr_win_d;
            debt_q <= debt_d;
            viol_q <= viol_d;
            pd_pre_q <= pd_pre_d;
            pd_act_q <= pd_act_d;
            sr_q <= sr_d;
            boff_q <= boff_d;
            vio_q <= vio_d;
        end
    end

    // Register slave, zero wait states
    assign addr_phase = hsel_i && hready_i && htrans_i[1];
    assign acc_addr = haddr_i[7:0];

    always_comb
    begin
        wr_pend_d = addr_phase && hwrite_i;
        wr_addr_d = addr_phase ? acc_addr : wr_addr_q;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        viol_clr = '0;
        if (addr_phase && !hwrite_i)
        begin
            if (acc_addr == ADDR_CTRL && haddr_i[31:8] == 24'h000000)
            begin
                rdata_d = {30'h00000000, ctrl_q};
            end
            else if (acc_addr == ADDR_STATUS && haddr_i[31:8] == 24'h000000)
            begin
                rdata_d = {12'h000, pd_pre_q, sr_win_q, state_q,
                    busy_v, open_v};
            end
            else if (acc_addr == ADDR_VIOL && haddr_i[31:8] == 24'h000000)
            begin
                rdata_d = {21'h000000, viol_q};
            end
            else
            begin
                rdata_d = 32'h00000000;
            end
        end
        if (wr_pend_q)
        begin
            if (wr_addr_q == ADDR_CTRL)
            begin
                ctrl_d = hwdata_i[1:0];
            end
            else if (wr_addr_q == ADDR_VIOL)
            begin
                viol_clr = hwdata_i[VIOL_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q <= 32'h00000000;
            ctrl_q <= CTRL_RESET;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
        end
    end

    assign hrdata_o = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign bank_open_o = open_v;
    assign pd_precharge_o = pd_pre_q;
    assign pd_active_o = pd_act_q;
    assign self_refresh_o = sr_q;
    assign dll_frozen_o = pd_pre_q;
    assign buffers_off_o = boff_q;
    assign violation_o = vio_q;

endmodule : drm_ctl

// ===== tb/drm_chk.sv
`timescale 1ns/100ps
module drm_chk
    import drm_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire drm_cmd_type cmd_i,
    input wire logic cke_i,
    input wire logic [7:0] bank_open_o,
    input wire logic pd_precharge_o,
    input wire logic pd_active_o,
    input wire logic self_refresh_o,
    input wire logic dll_frozen_o,
    input wire logic buffers_off_o,
    input wire logic violation_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    logic cke_q;
    logic cke_d;
    logic nm;
    logic go;
    logic ent;
    drm_op_type op;
    assign op = decode_cmd(cmd_i);
    assign nm = !(pd_precharge_o || pd_active_o || self_refresh_o);
    // Commands count only with the gate high on both edges
    assign go = nm && cke_q && cke_i;
    assign ent = nm && cke_q && !cke_i;
    always_comb cke_d = cke_i;
    always_ff @(posedge sys_clk_i or negedge nrst_i)
        if (!nrst_i)
            cke_q <= 1'b1;
        else
            cke_q <= cke_d;
    a_pre_all_close: assert property (
        go && op == CMD_PRE && cmd_i.all_bank_select_addr_bit
        |=> bank_open_o == 8'h00) else $error("bank left open");
    a_pre_one_bank: assert property (
        go && op == CMD_PRE && !cmd_i.all_bank_select_addr_bit
        |=> bank_open_o == ($past(bank_open_o)
        & ~(8'h01 << $past(cmd_i.ba)))) else $error("wrong bank closed");
    a_act_opens: assert property (go && op == CMD_ACT
        |=> bank_open_o == ($past(bank_open_o)
        | (8'h01 << $past(cmd_i.ba)))) else $error("wrong bank opened");
    a_sref_entry: assert property (ent && op == CMD_REF
        |=> self_refresh_o) else $error("self refresh not entered");
    a_pd_pre_entry: assert property (
        ent && op == CMD_NOP && bank_open_o == 8'h00
        |=> pd_precharge_o && dll_frozen_o && buffers_off_o)
        else $error("precharge power-down not entered");
    a_pd_act_entry: assert property (
        ent && op == CMD_NOP && bank_open_o != 8'h00
        |=> pd_active_o && !dll_frozen_o && buffers_off_o)
        else $error("active power-down not entered");
    a_pd_exit: assert property (
        (pd_precharge_o || pd_active_o) && cke_i && op == CMD_NOP
        |=> !pd_precharge_o && !pd_active_o) else $error("no pd exit");
    a_sref_exit: assert property (
        self_refresh_o && cke_i && op == CMD_NOP |=> !self_refresh_o)
        else $error("self refresh not left");
    a_idle_read: assert property (
        go && op == CMD_READ && !bank_open_o[cmd_i.ba] |=> violation_o)
        else $error("read of idle bank not flagged");
    a_pd_cke_low: assert property (
        $rose(pd_active_o || pd_precharge_o)
        |-> $past(cke_q) && !$past(cke_i)) else $error("pd without gate");
    c_sref: cover property (ent && op == CMD_REF);
    c_pd_act: cover property ($rose(pd_active_o));
    c_sref_exit: cover property ($fell(self_refresh_o));
endmodule : drm_chk

bind drm_ctl drm_chk u_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .cmd_i(cmd_i), .cke_i(cke_i), .bank_open_o(bank_open_o),
    .pd_precharge_o(pd_precharge_o), .pd_active_o(pd_active_o),
    .self_refresh_o(self_refresh_o), .dll_frozen_o(dll_frozen_o),
    .buffers_off_o(buffers_off_o), .violation_o(violation_o));

// ===== tb/drm_host.sv
`timescale 1ns/100ps
module drm_host
    import drm_pkg::*;
(
    input wire logic sys_clk_i,
    output drm_cmd_type cmd_o,
    output logic cke_o,
    output logic term_o
);
    logic slow = 1'b0;
    initial
    begin
        cmd_o = 8'hFF;
        cke_o = 1'b1;
        term_o = 1'b0;
    end
    // caller keeps refresh, exit and entry order
    task automatic send(input logic [2:0] rcw, input logic a,
        input logic [2:0] b, input logic k, input int n);
        int x;
        x = slow ? n + int'($urandom_range(2)) : n;
        // Two edges at least, or the deselect meets the next command
        if (x < 2)
            x = 2;
        cmd_o <= {1'b0, rcw, a, b};
        cke_o <= k;
        repeat (x - 1)
        begin
            @(posedge sys_clk_i);
            // Deselected pins wander, never a stale command
            cmd_o <= {1'b1, 7'($urandom)};
        end
        @(posedge sys_clk_i);
    endtask : send
endmodule : drm_host

// ===== tb/dram_precharge_refresh_powerdown_bench.sv
`timescale 1ns/100ps
module dram_precharge_refresh_powerdown_bench
    import drm_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [7:0] bank_open;
    logic pd_pre;
    logic pd_act;
    logic sref;
    logic dll;
    logic boff;
    logic vio;
    drm_cmd_type cmd;
    logic cke;
    logic term;
    int err_count = 0;
    int cmp_count = 0;
    logic [7:0] exp_open = 8'h00;
    logic [31:0] rd;
    logic [31:0] v;
    logic [7:0] m;
    logic [2:0] b;
    wire logic [7:0] pw = {3'h0, pd_act, pd_pre, sref, dll, boff};

    always #2 clk = ~clk;

    drm_host hs (.sys_clk_i(clk), .cmd_o(cmd), .cke_o(cke), .term_o(term));
    drm_ctl dut (.sys_clk_i(clk), .nrst_i(rst_n), .cmd_i(cmd),
        .cke_i(cke), .termination_enable_input_i(term), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .bank_open_o(bank_open), .pd_precharge_o(pd_pre),
        .pd_active_o(pd_act), .self_refresh_o(sref),
        .dll_frozen_o(dll), .buffers_off_o(boff), .violation_o(vio));

    function automatic logic [7:0] nxt_open(input logic [7:0] o,
        input logic [2:0] rcw, input logic a, input logic [2:0] bk);
        logic [7:0] s;
        s = 8'h01 << bk;
        if (rcw == 3'b011)
            return o | s;
        if (rcw == 3'b010)
            return a ? 8'h00 : (o & ~s);
        // Refresh leaves every bank idle
        if (rcw == 3'b001)
            return 8'h00;
        return o;
    endfunction : nxt_open

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t reg %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t pins %h exp %h", $time, got, exp);
        end
        // Back onto the edge for the next drive
        @(posedge clk);
    endtask : chk_pin

    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        r = hrdata;
    endtask : ahb

    task automatic cmd_go(input logic [2:0] rcw, input logic a,
        input logic [2:0] bk, input logic k, input int n);
        if (k)
            exp_open = nxt_open(exp_open, rcw, a, bk);
        hs.send(rcw, a, bk, k, n);
    endtask : cmd_go

    task automatic viol(input int bit_i);
        ahb(1'b0, ADDR_VIOL, 32'h0, rd);
        chk_reg(rd, 32'h1 << bit_i);
        #1 chk_pin({7'h0, vio}, 8'h01);
        ahb(1'b1, ADDR_VIOL, 32'h1 << bit_i, rd);
        ahb(1'b0, ADDR_VIOL, 32'h0, rd);
        chk_reg(rd, 32'h0);
    endtask : viol

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    // Far beyond the few hundred cycles the tests need
    initial
    begin
        #80000;
        err_count++;
        results();
    end

    initial
    begin
        void'($urandom(69896));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            ahb(1'b0, 8'(i * 4), 32'h0, rd);
            chk_reg(rd, 32'h0);
            ahb(1'b1, 8'(i * 4), 32'hFFFFFFFF, rd);
            ahb(1'b0, 8'(i * 4), 32'h0, rd);
            chk_reg(rd, (i == 0) ? 32'h3 : 32'h0);
        end
        v = $urandom;
        ahb(1'b1, ADDR_CTRL, v, rd);
        ahb(1'b0, ADDR_CTRL, 32'h0, rd);
        chk_reg(rd, v & 32'h3);
        ahb(1'b1, ADDR_CTRL, 32'h1, rd);
        #1 chk_pin({7'h0, hresp}, 8'h00);
        $display("test registers done");
        m = 8'($urandom) | 8'h01;
        for (int i = 0; i < 8; i++)
            if (m[i])
                cmd_go(3'b011, 1'b0, 3'(i), 1'b1, 1);
        #1 chk_pin(bank_open, exp_open);
        hs.slow = 1'b1;
        cmd_go(3'b101, 1'b0, 3'h0, 1'b1, int'(READ_BUSY_CYC));
        cmd_go(3'b100, 1'b0, 3'h0, 1'b1, int'(WRITE_BUSY_CYC));
        cmd_go(3'b111, 1'b0, 3'h0, 1'b0, 3);
        #1 chk_pin(pw, 8'h11);
        ahb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk_reg(rd, {14'h0, 2'h2, 8'h00, exp_open});
        cmd_go(3'b111, 1'b0, 3'h0, 1'b1, int'(XARDS_CYC));
        #1 chk_pin(pw, 8'h00);
        cmd_go(3'b101, 1'b0, 3'h0, 1'b1, int'(READ_BUSY_CYC));
        b = 3'($urandom);
        b = m[b] ? b : 3'h0;
        cmd_go(3'b010, 1'b0, b, 1'b1, int'(RP_CYC));
        #1 chk_pin(bank_open, exp_open);
        cmd_go(3'b010, 1'b1, 3'($urandom), 1'b1, int'(RPA_CYC));
        #1 chk_pin(bank_open, 8'h00);
        ahb(1'b0, ADDR_VIOL, 32'h0, rd);
        chk_reg(rd, 32'h0);
        $display("test banks and active power-down done");
        cmd_go(3'b111, 1'b0, 3'h0, 1'b0, 3);
        #1 chk_pin(pw, 8'h0B);
        ahb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk_reg(rd, 32'h00090000);
        cmd_go(3'b111, 1'b0, 3'h0, 1'b1, int'(XP_CYC));
        cmd_go(3'b001, 1'b0, 3'h0, 1'b1, 1);
        ahb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk_reg(rd, 32'h0000FF00);
        cmd_go(3'b111, 1'b0, 3'h0, 1'b1, int'(RFC_CYC));
        $display("test precharge power-down and refresh done");
        cmd_go(3'b101, 1'b0, 3'h5, 1'b1, 1);
        viol(V_RDWR_IDLE);
        cmd_go(3'b011, 1'b0, 3'h2, 1'b1, 1);
        cmd_go(3'b001, 1'b0, 3'h0, 1'b1, int'(RFC_CYC));
        viol(V_REF_OPEN);
        ahb(1'b1, ADDR_CTRL, 32'h0, rd);
        cmd_go(3'b011, 1'b0, 3'h2, 1'b1, 2);
        cmd_go(3'b101, 1'b0, 3'h2, 1'b1, 2);
        cmd_go(3'b111, 1'b0, 3'h0, 1'b0, 3);
        cmd_go(3'b111, 1'b0, 3'h0, 1'b1, int'(XARD_CYC));
        cmd_go(3'b101, 1'b0, 3'h2, 1'b1, int'(READ_BUSY_CYC));
        viol(V_CKE_ACCESS);
        cmd_go(3'b010, 1'b1, 3'h0, 1'b1, int'(RPA_CYC));
        $display("test flagged sequences done");
        cmd_go(3'b001, 1'b0, 3'h0, 1'b0, 3);
        #1 chk_pin(pw, 8'h05);
        ahb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk_reg(rd & 32'h000F00FF, 32'h00030000);
        cmd_go(3'b111, 1'b0, 3'h0, 1'b1, 1);
        ahb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk_reg(rd & 32'h000F0000, 32'h00040000);
        #1 chk_pin(pw, 8'h00);
        cmd_go(3'b111, 1'b0, 3'h0, 1'b1, int'(XSNR_CYC));
        cmd_go(3'b011, 1'b0, 3'h1, 1'b1, 1);
        cmd_go(3'b101, 1'b0, 3'h1, 1'b1, int'(XSRD_CYC));
        viol(V_EARLY_READ);
        $display("test self refresh done");
        results();
    end
endmodule : dram_precharge_refresh_powerdown_bench
